// ==== hdl/acc_pkg.sv ====
package acc_pkg;
    // byte offsets of the converter registers
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h24;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h25;
    localparam logic [7:0] ADDR_CONTROL = 8'h26;
    localparam logic [7:0] ADDR_CLOCK_SEL = 8'h27;
    // control register fields
    localparam int CTL_CHAN_LSB = 0;
    localparam int CTL_PIN_CFG_LSB = 3;
    localparam int CTL_DONE_N_BIT = 6;
    localparam int CTL_START_BIT = 7;
    // clock select fields
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_TEST_BIT = 7;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CLOCK_SEL_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // converter clock dividers for codes 00, 01, 10
    localparam int DIV_CODE0 = 2;
    localparam int DIV_CODE1 = 8;
    localparam int DIV_CODE2 = 32;
    // sampling and full conversion, in converter clock periods
    localparam int SAMPLE_PERIODS = 32;
    localparam int CONV_PERIODS = 80;
    localparam int CHANNELS = 8;
    localparam int RESULT_BITS = 12;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_ARMED,
        ACC_SAMPLE,
        ACC_CONVERT
    } acc_state_t;
endpackage

// ==== hdl/acc_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// converter clock tick generator, one pulse per divided period
module acc_clk_div (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic [1:0] i_div_code,
    output logic o_tick
);
    logic [5:0] count_r;
    logic [5:0] limit;

    // code 11 is undefined; treated as the slowest divider
    always_comb
    begin
        unique case (i_div_code)
            2'b00: limit = 6'(acc_pkg::DIV_CODE0 - 1);
            2'b01: limit = 6'(acc_pkg::DIV_CODE1 - 1);
            default: limit = 6'(acc_pkg::DIV_CODE2 - 1);
        endcase
    end

    // free counter restarted with each new conversion
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst || i_clear || count_r >= limit)
            count_r <= 6'h00;
        else
            count_r <= count_r + 6'h01;
    end

    assign o_tick = (count_r >= limit) && !i_clear;
endmodule
`default_nettype wire

// ==== hdl/acc_core.sv ====
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] eight analog channels, twelve-bit result per conversion
// [R02] control bits 2..0 pick the converted channel
// [R03] control bits 5..3 split port pins into analog and digital
// [R04] analog pins lose digital I/O and pull-high; converter powered
// [R05] pin configuration zero powers the converter down
// [R06] control bit 6 is done flag, zero when conversion finished
// [R07] start rising edge resets converter and sets done flag
// [R08] conversion begins after start rises then falls
// [R09] software holds start low until done flag clears
// [R10] each completed conversion raises the interrupt request
// [R11] result bytes are read-only and hold the result
// [R12] clock select 00/01/10 divides system clock by 2/8/32
// [R13] clock select bits 2..6 read as zero
// [R14] software leaves clock select bit 7 for test use
// [R15] software pulses start within ten cycles after pin change
// [R16] no start pulse needed when pin configuration is zero
// [R17] channel codes 000..111 map to inputs zero..seven
// [R18] pin code k makes the lowest k pins analog; the code makes all eight pins analog at code 7
// [R19] result 11..4 in high byte, 3..0 in low upper nibble
// [R20] sampling 32 and conversion 80 converter clock periods
// [R21] results keep old value until next conversion completes
module acc_core #(
    parameter int CHANNELS = acc_pkg::CHANNELS,
    parameter int RESULT_BITS = acc_pkg::RESULT_BITS
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic [2:0] o_chan_sel,
    output logic [CHANNELS-1:0] o_pin_analog,
    output logic [CHANNELS-1:0] o_pin_pullup_en,
    output logic o_conv_power,
    output logic o_sample_hold,
    output logic o_conv_reset,
    input wire logic [RESULT_BITS-1:0] i_conv_data,
    output logic o_irq_req,
    output logic o_test_mode
);
    logic [2:0] chan_r;
    logic [2:0] pin_cfg_r;
    logic start_r;
    logic done_n_r;
    logic [1:0] div_r;
    logic test_r;
    logic [RESULT_BITS-1:0] result_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic [6:0] period_r;
    logic tick;
    logic wr_ctl;
    logic wr_clk;
    logic start_new;
    logic start_rise;
    logic start_fall;
    logic conv_end;
    acc_pkg::acc_state_t state_r;
    acc_pkg::acc_state_t state_nxt;

    // thermometer decode of the pin configuration code
    function automatic logic [CHANNELS-1:0] pin_mask(input logic [2:0] k);
        logic [CHANNELS-1:0] m;
        m = '0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (k == 3'b111 || i < int'(k))
                m[i] = 1'b1;
        end
        return m;
    endfunction

    // one strobe qualified by one register offset
    function automatic logic reg_hit(input logic strobe,
        input logic [7:0] addr, input logic [7:0] offset);
        return strobe && (addr == offset);
    endfunction

    // write decode; result offsets have no write path at all
    assign wr_ctl = reg_hit(i_wr, i_addr, acc_pkg::ADDR_CONTROL);
    assign wr_clk = reg_hit(i_wr, i_addr, acc_pkg::ADDR_CLOCK_SEL);
    assign start_new = i_wdata[acc_pkg::CTL_START_BIT];
    // [R07] start edge detect
    assign start_rise = wr_ctl && start_new && !start_r;
    // [R08] start falling edge
    assign start_fall = wr_ctl && !start_new && start_r;

    // [R02] channel select written
    // [R03] pin configuration split
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            chan_r <= acc_pkg::CONTROL_RESET[2:0];
            pin_cfg_r <= acc_pkg::CONTROL_RESET[5:3];
            start_r <= acc_pkg::CONTROL_RESET[7];
        end
        else if (wr_ctl)
        begin
            chan_r <= i_wdata[acc_pkg::CTL_CHAN_LSB +: 3];
            pin_cfg_r <= i_wdata[acc_pkg::CTL_PIN_CFG_LSB +: 3];
            start_r <= start_new;
        end
    end

    // [R12] clock select; test bit is stored, read back in bit 7 and drives only o_test_mode
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            div_r <= acc_pkg::CLOCK_SEL_RESET[1:0];
            test_r <= acc_pkg::CLOCK_SEL_RESET[7];
        end
        else if (wr_clk)
        begin
            div_r <= i_wdata[acc_pkg::CLK_DIV_LSB +: 2];
            test_r <= i_wdata[acc_pkg::CLK_TEST_BIT];
        end
    end

    // divider restarts with the launch so periods align to it
    acc_clk_div u_div (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_clear(start_fall),
        .i_div_code(div_r),
        .o_tick(tick)
    );

    // [R20] last converter period of the full conversion
    assign conv_end = (state_r == acc_pkg::ACC_CONVERT) && tick &&
        (period_r == 7'(acc_pkg::CONV_PERIODS - 1));

    // sequence: armed by rising start, launched by falling start
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            acc_pkg::ACC_IDLE:
            begin
                if (start_rise)
                begin
                    state_nxt = acc_pkg::ACC_ARMED;
                end
            end
            acc_pkg::ACC_ARMED:
            begin
                // [R08] launch on falling edge
                if (start_fall)
                begin
                    state_nxt = acc_pkg::ACC_SAMPLE;
                end
            end
            acc_pkg::ACC_SAMPLE:
            begin
                // [R20] sampling window length
                if (tick && period_r == 7'(acc_pkg::SAMPLE_PERIODS - 1))
                begin
                    state_nxt = acc_pkg::ACC_CONVERT;
                end
            end
            acc_pkg::ACC_CONVERT:
            begin
                if (conv_end)
                begin
                    state_nxt = acc_pkg::ACC_IDLE;
                end
            end
        endcase
        // [R07] a new rising start aborts and rearms
        if (start_rise)
        begin
            state_nxt = acc_pkg::ACC_ARMED;
        end
        // [R05] powered-down converter never runs
        if (pin_cfg_r == 3'b000 && !(wr_ctl && start_new))
        begin
            state_nxt = acc_pkg::ACC_IDLE;
        end
    end

    // sequence register; an abort simply lands in armed again
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            state_r <= acc_pkg::ACC_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // converter period counter across sampling and conversion
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst || state_r == acc_pkg::ACC_IDLE ||
            state_r == acc_pkg::ACC_ARMED)
        begin
            period_r <= 7'h00;
        end
        else if (tick)
        begin
            period_r <= period_r + 7'h01;
        end
    end

    // [R06] done flag cleared at conversion end
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            done_n_r <= acc_pkg::CONTROL_RESET[6];
        end
        else if (start_rise)
        begin
            // [R07] rising start sets flag
            done_n_r <= 1'b1;
        end
        else if (conv_end)
        begin
            done_n_r <= 1'b0;
        end
    end

    // [R21] result held until the next completion
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            result_r <= acc_pkg::RESULT_RESET;
        end
        else if (conv_end)
        begin
            // [R01] capture twelve-bit result
            result_r <= i_conv_data;
        end
    end

    // [R10] one-cycle request at each completion
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= conv_end;
        end
    end

    // read data valid in the cycle after the read strobe
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            rdata_r <= 8'h00;
        end
        else if (i_rd)
        begin
            unique case (i_addr)
                // [R19] low byte keeps result bits 3..0 on top
                acc_pkg::ADDR_RESULT_LOW:
                    rdata_r <= {result_r[3:0], 4'h0};
                // [R11] read-only result bytes
                acc_pkg::ADDR_RESULT_HIGH:
                    rdata_r <= result_r[11:4];
                acc_pkg::ADDR_CONTROL:
                    rdata_r <= {start_r, done_n_r, pin_cfg_r, chan_r};
                // [R13] unused clock select bits read zero
                acc_pkg::ADDR_CLOCK_SEL:
                    rdata_r <= {test_r, 5'h00, div_r};
                default:
                    rdata_r <= 8'h00;
            endcase
        end
        else
        begin
            // bus idles at zero so a stale byte never lingers
            rdata_r <= 8'h00;
        end
    end

    assign o_rdata = rdata_r;
    // [R17] channel code drives the analog multiplexer directly
    assign o_chan_sel = chan_r;
    // [R18] lowest k pins analog, all eight pins at code 7
    assign o_pin_analog = pin_mask(pin_cfg_r);
    // [R04] analog pins drop pull-high, converter powered
    assign o_pin_pullup_en = ~pin_mask(pin_cfg_r);
    // [R05] power off at code zero
    assign o_conv_power = (pin_cfg_r != 3'b000);
    // phase strobes for the analog side, decoded from state
    assign o_sample_hold = (state_r == acc_pkg::ACC_SAMPLE);
    assign o_conv_reset = (state_r == acc_pkg::ACC_ARMED);
    assign o_irq_req = irq_r;
    assign o_test_mode = test_r;
endmodule
`default_nettype wire

// ==== verification/acc_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// port checker; outputs judged against bus writes and reads, against each other and over time
module acc_core_props #(
    parameter int CHANNELS = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0] o_chan_sel,
    input wire logic [CHANNELS-1:0] o_pin_analog,
    input wire logic [CHANNELS-1:0] o_pin_pullup_en,
    input wire logic o_conv_power,
    input wire logic o_sample_hold,
    input wire logic o_conv_reset,
    input wire logic o_irq_req,
    input wire logic o_test_mode
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    logic wr_ctl;
    logic wr_clk;
    // decoded writes
    assign wr_ctl = i_wr && (i_addr == acc_pkg::ADDR_CONTROL);
    assign wr_clk = i_wr && (i_addr == acc_pkg::ADDR_CLOCK_SEL);
    // code 7 is all eight pins, not seven
    function automatic logic [7:0] therm(input logic [7:0] w);
        if (w[5:3] == 3'd7)
            return 8'hFF;
        return 8'((9'h001 << w[5:3]) - 9'h001);
    endfunction
    // arming released while powered
    sequence s_release;
        $fell(o_conv_reset) ##0 o_conv_power;
    endsequence
    a_pull_inverse: assert property (o_pin_pullup_en == ~o_pin_analog)
        else $error("pull-up not inverse of analog");
    a_power_pins: assert property (o_conv_power == (o_pin_analog != '0))
        else $error("power does not follow pins");
    a_pin_thermo: assert property (wr_ctl |=> o_pin_analog == therm($past(i_wdata)))
        else $error("analog pins wrong");
    a_chan_follow: assert property (wr_ctl |=> o_chan_sel == 3'($past(i_wdata)))
        else $error("channel select wrong");
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data without read");
    a_clk_unused: assert property (i_rd && i_addr == acc_pkg::ADDR_CLOCK_SEL |=> o_rdata[6:2] == 5'h00)
        else $error("unused clock bits not zero");
    a_irq_single: assert property (o_irq_req |=> !o_irq_req)
        else $error("irq longer than a cycle");
    a_arm_sample: assert property (s_release |-> ##[0:1] o_sample_hold)
        else $error("no sampling after release");
    a_test_store: assert property (wr_clk |=> o_test_mode == 1'($past(i_wdata) >> 7))
        else $error("test bit not stored");
endmodule
bind acc_core acc_core_props #(.CHANNELS(CHANNELS)) i_props (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_chan_sel(o_chan_sel), .o_pin_analog(o_pin_analog),
    .o_pin_pullup_en(o_pin_pullup_en), .o_conv_power(o_conv_power),
    .o_sample_hold(o_sample_hold), .o_conv_reset(o_conv_reset),
    .o_irq_req(o_irq_req), .o_test_mode(o_test_mode));
`default_nettype wire

// ==== verification/acc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// analog source; each input has its own level so a wrong route shows
module acc_analog_model (
    input wire logic [2:0] i_chan,
    output logic [11:0] o_level
);
    assign o_level = 12'h5A3 ^ {4{i_chan}};
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, pa, pu;
    logic [2:0] chan;
    logic pw, sh, cr, irq, tm;
    logic [11:0] lvl;
    int bad_count = 0;
    int total_checks = 0;
    // 200 MHz
    initial forever #2.5 clk = ~clk;
    acc_core i_acc_core (.i_ref_clk(clk), .i_srst(srst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_chan_sel(chan), .o_pin_analog(pa), .o_pin_pullup_en(pu),
        .o_conv_power(pw), .o_sample_hold(sh), .o_conv_reset(cr),
        .i_conv_data(lvl), .o_irq_req(irq), .o_test_mode(tm));
    acc_analog_model i_acc_analog_model (.i_chan(chan), .o_level(lvl));
    task automatic tally_and_finish();
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    function automatic logic [7:0] therm(input int k);
        return (k == 7) ? 8'hFF : 8'((9'h001 << k) - 9'h001);
    endfunction
    function automatic logic [11:0] lv(input int c);
        return 12'h5A3 ^ {4{3'(c)}};
    endfunction
    // main sequence
    initial
    begin
        int n;
        int hold;
        int dv;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h25, 8'h00);
        rd_chk(8'h30, 8'h00);
        wr_reg(8'h27, 8'h7F);
        rd_chk(8'h27, 8'h03);
        chk(tm, 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(8'h26, 8'((k << 3) | (7 - k)));
            rd_chk(8'h26, 8'((k << 3) | (7 - k)));
            chk(pa, therm(k));
            chk(pu, 8'(~therm(k)));
            chk(pw, k != 0);
            chk(chan, 7 - k);
        end
        // one conversion per divider code, timed from the falling write
        for (int c = 0; c < 3; c++)
        begin
            dv = 2 << (2 * c);
            wr_reg(8'h27, 8'(c));
            wr_reg(8'h26, 8'(8'hBC + c));
            rd_chk(8'h26, 8'(8'hFC + c));
            chk(cr, 1'b1);
            wr_reg(8'h26, 8'(8'h3C + c));
            n = 0;
            hold = 0;
            while (irq !== 1'b1 && n < 3000)
            begin
                @(posedge clk);
                #1 n++;
                hold += int'(sh === 1'b1);
            end
            if (n >= 3000)
            begin
                chk(16'h0000, 16'h0001);
                tally_and_finish();
            end
            chk(n >= 80 * dv && n <= 80 * dv + 3, 1'b1);
            chk(hold >= 32 * dv - 1 && hold <= 32 * dv + 1, 1'b1);
            rd_chk(8'h26, 8'(8'h3C + c));
            rd_chk(8'h25, 8'(lv(c + 4) >> 4));
            rd_chk(8'h24, 8'(lv(c + 4) << 4));
        end
        // result must survive a write and a channel change
        wr_reg(8'h25, 8'hFF);
        wr_reg(8'h26, 8'h39);
        rd_chk(8'h25, 8'(lv(6) >> 4));
        rd_chk(8'h24, 8'(lv(6) << 4));
        tally_and_finish();
    end
endmodule
`default_nettype wire
